// ===== core/mis_core.sv
// Implementation choices: the register offsets and the APB interface to the registers.
`include "mis_defines.svh"

// Operation
// - call pushes pc plus one, loads target
// - call takes two instruction cycles
// - memory clear writes zero, flags kept
// - bit clear zeroes only selected bit
// - watchdog clear resets counter, both flags
// - pre-clears act only when alternated
// - flags cleared only after consecutive pair
// - invert memory byte in place
// - inverse to accumulator, zero flag only
// - low nibble plus six if over nine
// - high nibble plus six if over nine
// - adjusted value to memory, carry only
// - memory decrement in place, zero flag
// - decrement to accumulator, memory kept
// - sleep halts execution, keeps accumulator and memory
// - sleep clears watchdog, sets sleep flag
module mis_core #(
  parameter int DMEM_DEPTH = 64,
  parameter int STACK_DEPTH = 4,
  parameter int PC_W = 10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // instruction issue
  input wire logic ins_valid,
  input wire mis_pkg::mis_ins_t ins,
  output logic ins_ready,
  output logic [PC_W-1:0] pc_o,
  // watchdog and power
  input wire logic wdt_timeout_i,
  input wire logic wake_i,
  output logic wdt_clear_o,
  output logic sleep_o,
  // interrupt
  output logic irq
);
  import mis_pkg::*;

  localparam int AW = (DMEM_DEPTH > 1) ? $clog2(DMEM_DEPTH) : 1;
  localparam int SW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  if (DMEM_DEPTH < 2 || DMEM_DEPTH > 256 || (1 << AW) != DMEM_DEPTH) begin : g_chk_mem
    $error("data memory depth must be a power of two from 2 to 256");
  end
  if (STACK_DEPTH < 2 || (1 << SW) != STACK_DEPTH) begin : g_chk_stack
    $error("stack depth must be a power of two of at least 2");
  end
  if (PC_W < 1 || PC_W > 16) begin : g_chk_pc
    $error("program counter width must be 1 to 16");
  end

  logic [7:0] dmem [DMEM_DEPTH];
  logic [PC_W-1:0] stack [STACK_DEPTH];
  logic [7:0] acc_r;
  logic z_r;
  logic c_r;
  logic ac_r;
  logic to_r;
  logic pdf_r;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] target_r;
  logic [SW-1:0] sp_r;
  logic [SW:0] depth_r;
  mis_state_t state_r;
  mis_pre_t pre_r;
  logic [AW-1:0] maddr_r;
  logic [`MIS_NUM_EV-1:0] istat_r;
  logic [`MIS_NUM_EV-1:0] imask_r;
  logic wdt_clear_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  logic take;
  logic [AW-1:0] ins_a;
  logic [7:0] mem_rd;
  logic [8:0] bcd_sum;
  logic [7:0] minus_one;
  logic pre_hit;
  logic wdt_clr;
  logic mem_we;
  logic [7:0] mem_wd;
  logic apb_setup;
  logic apb_wr;
  logic [2:0] wr_idx;
  logic [`MIS_NUM_EV-1:0] ev;

  // register index from address; 7 means unmapped
  function automatic logic [2:0] reg_idx(input logic [11:0] a);
    if (a == `MIS_OFS_CORE) begin
      return 3'h0;
    end else if (a == `MIS_OFS_PC) begin
      return 3'h1;
    end else if (a == `MIS_OFS_MADDR) begin
      return 3'h2;
    end else if (a == `MIS_OFS_MDATA) begin
      return 3'h3;
    end else if (a == `MIS_OFS_ISTAT) begin
      return 3'h4;
    end else if (a == `MIS_OFS_IMASK) begin
      return 3'h5;
    end else if (a == `MIS_OFS_STACK) begin
      return 3'h6;
    end else begin
      return 3'h7;
    end
  endfunction : reg_idx

  // correction from the original nibbles; carry out of bit 7 in bit 8
  function automatic logic [8:0] bcd_fix(input logic [7:0] a, input logic c, input logic ac);
    logic [7:0] corr;
    corr = 8'h00;
    if (a[3:0] > `MIS_BCD_LIMIT || ac) begin
      corr = corr | `MIS_BCD_LO;
    end
    if (a[7:4] > `MIS_BCD_LIMIT || c) begin
      corr = corr | `MIS_BCD_HI;
    end
    return {1'b0, a} + {1'b0, corr};
  endfunction : bcd_fix

  // the second call cycle and sleep both hold the issue port
  assign ins_ready = (state_r == ST_RUN);
  assign take = ins_valid && ins_ready;
  assign ins_a = ins.maddr[AW-1:0];
  assign mem_rd = dmem[ins_a];
  assign bcd_sum = bcd_fix(acc_r, c_r, ac_r);
  assign minus_one = mem_rd - 8'h01;
  assign pre_hit = take &&
    ((ins.op == MIS_WATCHDOG_PRECLEAR_FIRST && pre_r == PRE_SECOND) ||
     (ins.op == MIS_WATCHDOG_PRECLEAR_SECOND && pre_r == PRE_FIRST));
  assign wdt_clr = pre_hit || (take && (ins.op == MIS_CLR_WDT || ins.op == MIS_SLEEP));

  // zero wait states: every register answers from flops
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign wr_idx = reg_idx(paddr);
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign pc_o = pc_r;
  assign wdt_clear_o = wdt_clear_r;
  assign sleep_o = (state_r == ST_SLEEP);
  // level output, drops once software clears or masks the cause
  assign irq = |(istat_r & imask_r);

  always_comb begin
    mem_we = take;
    mem_wd = mem_rd;
    case (ins.op)
      MIS_CLR_MEM: mem_wd = 8'h00;
      MIS_CLR_BIT: mem_wd = mem_rd & ~(8'h01 << ins.bit_sel);
      MIS_INVERT_MEM: mem_wd = ~mem_rd;
      MIS_BCD_ADJUST: mem_wd = bcd_sum[7:0];
      MIS_MEM_MINUS_ONE: mem_wd = minus_one;
      default: mem_we = 1'b0;
    endcase
  end

  // instruction write wins over a software write in the same cycle
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      dmem[ins_a] <= mem_wd;
    end else if (apb_wr && wr_idx == 3'h3) begin
      dmem[maddr_r] <= pwdata[7:0];
    end
  end

  // a taken instruction wins over a software write to the core register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= `MIS_RST_ACC;
      z_r <= 1'b0;
      c_r <= 1'b0;
      ac_r <= 1'b0;
    end else if (take) begin
      case (ins.op)
        MIS_INVERT_TO_ACCUMULATOR: begin
          acc_r <= ~mem_rd;
          z_r <= (~mem_rd == 8'h00);
        end
        MIS_MEM_MINUS_ONE_TO_ACCUMULATOR: begin
          acc_r <= minus_one;
          z_r <= (minus_one == 8'h00);
        end
        MIS_MEM_MINUS_ONE: z_r <= (minus_one == 8'h00);
        MIS_BCD_ADJUST: c_r <= c_r | bcd_sum[8];
        default: ;
      endcase
    end else if (apb_wr && wr_idx == 3'h0) begin
      acc_r <= pwdata[7:0];
      z_r <= pwdata[`MIS_BIT_Z];
      c_r <= pwdata[`MIS_BIT_C];
      ac_r <= pwdata[`MIS_BIT_AC];
    end
  end

  // pulse one cycle after the clearing instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_clear_r <= 1'b0;
    end else begin
      wdt_clear_r <= wdt_clr;
    end
  end

  // a timeout in the clearing cycle still sets the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_r <= 1'b0;
    end else if (wdt_timeout_i) begin
      to_r <= 1'b1;
    end else if (wdt_clr) begin
      to_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdf_r <= 1'b0;
    end else if (take && ins.op == MIS_SLEEP) begin
      pdf_r <= 1'b1;
    end else if (wdt_clr) begin
      pdf_r <= 1'b0;
    end
  end

  // any other instruction breaks the pre-clear pairing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= PRE_NONE;
    end else if (take) begin
      case (ins.op)
        MIS_WATCHDOG_PRECLEAR_FIRST: pre_r <= PRE_FIRST;
        MIS_WATCHDOG_PRECLEAR_SECOND: pre_r <= PRE_SECOND;
        default: pre_r <= PRE_NONE;
      endcase
    end
  end

  // pc moves only on a taken instruction or the second call cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RUN;
      pc_r <= PC_W'(`MIS_RST_PC);
      target_r <= PC_W'(`MIS_RST_PC);
    end else begin
      case (state_r)
        ST_RUN: begin
          if (take) begin
            pc_r <= pc_r + 1'b1;
            if (ins.op == MIS_CALL) begin
              target_r <= ins.target[PC_W-1:0];
              state_r <= ST_CALL2;
            end else if (ins.op == MIS_SLEEP) begin
              state_r <= ST_SLEEP;
            end
          end
        end
        ST_CALL2: begin
          pc_r <= target_r;
          state_r <= ST_RUN;
        end
        ST_SLEEP: begin
          if (wake_i) begin
            state_r <= ST_RUN;
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // oldest return address is overwritten when nesting runs too deep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_r <= '0;
      depth_r <= '0;
    end else if (take && ins.op == MIS_CALL) begin
      sp_r <= sp_r + 1'b1;
      if (depth_r != STACK_DEPTH[SW:0]) begin
        depth_r <= depth_r + 1'b1;
      end
    end
  end

  // pushed value is the address after the call
  always_ff @(posedge pclk) begin
    if (take && ins.op == MIS_CALL) begin
      stack[sp_r] <= pc_r + 1'b1;
    end
  end

  // overflow flagged on the push that overwrites the oldest entry
  always_comb begin
    ev = '0;
    ev[`MIS_EV_SLEEP] = take && ins.op == MIS_SLEEP;
    ev[`MIS_EV_TIMEOUT] = wdt_timeout_i;
    ev[`MIS_EV_OVF] = take && ins.op == MIS_CALL && depth_r == STACK_DEPTH[SW:0];
  end

  // set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= `MIS_RST_EV;
    end else if (apb_wr && wr_idx == 3'h4) begin
      istat_r <= (istat_r & ~pwdata[`MIS_NUM_EV-1:0]) | ev;
    end else begin
      istat_r <= istat_r | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_r <= `MIS_RST_EV;
    end else if (apb_wr && wr_idx == 3'h5) begin
      imask_r <= pwdata[`MIS_NUM_EV-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maddr_r <= '0;
    end else if (apb_wr && wr_idx == 3'h2) begin
      maddr_r <= pwdata[AW-1:0];
    end
  end

  // read data is captured in the setup cycle, so no wait state is needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (apb_setup) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= (reg_idx(paddr) == 3'h7);
      case (reg_idx(paddr))
        3'h0: begin
          prdata_r[7:0] <= acc_r;
          prdata_r[`MIS_BIT_Z] <= z_r;
          prdata_r[`MIS_BIT_C] <= c_r;
          prdata_r[`MIS_BIT_AC] <= ac_r;
          prdata_r[`MIS_BIT_TO] <= to_r;
          prdata_r[`MIS_BIT_PDF] <= pdf_r;
          prdata_r[`MIS_BIT_SLEEP] <= (state_r == ST_SLEEP);
        end
        3'h1: begin
          prdata_r[PC_W-1:0] <= pc_r;
          prdata_r[`MIS_BIT_SP +: SW + 1] <= depth_r;
        end
        3'h2: prdata_r[AW-1:0] <= maddr_r;
        3'h3: prdata_r[7:0] <= dmem[maddr_r];
        3'h4: prdata_r[`MIS_NUM_EV-1:0] <= istat_r;
        3'h5: prdata_r[`MIS_NUM_EV-1:0] <= imask_r;
        // top of the return stack, so pushes can be seen
        3'h6: prdata_r[PC_W-1:0] <= stack[sp_r - 1'b1];
        default: ;
      endcase
    end
  end
endmodule : mis_core

// ===== core/mis_defines.svh
`ifndef MIS_DEFINES_SVH
`define MIS_DEFINES_SVH
`define MIS_OFS_CORE 12'h000
`define MIS_OFS_PC 12'h004
`define MIS_OFS_MADDR 12'h008
`define MIS_OFS_MDATA 12'h00c
`define MIS_OFS_ISTAT 12'h010
`define MIS_OFS_IMASK 12'h014
`define MIS_OFS_STACK 12'h018
`define MIS_BIT_Z 8
`define MIS_BIT_C 9
`define MIS_BIT_AC 10
`define MIS_BIT_TO 11
`define MIS_BIT_PDF 12
`define MIS_BIT_SLEEP 13
`define MIS_BIT_SP 16
`define MIS_EV_SLEEP 0
`define MIS_EV_TIMEOUT 1
`define MIS_EV_OVF 2
`define MIS_NUM_EV 3
`define MIS_RST_ACC 8'h00
`define MIS_RST_PC 16'h0000
`define MIS_RST_EV 3'h0
`define MIS_BCD_LIMIT 4'h9
`define MIS_BCD_LO 8'h06
`define MIS_BCD_HI 8'h60
`endif

// ===== core/mis_pkg.sv
package mis_pkg;
  typedef enum logic [3:0] {
    MIS_NOP,
    MIS_CALL,
    MIS_CLR_MEM,
    MIS_CLR_BIT,
    MIS_CLR_WDT,
    MIS_WATCHDOG_PRECLEAR_FIRST,
    MIS_WATCHDOG_PRECLEAR_SECOND,
    MIS_INVERT_MEM,
    MIS_INVERT_TO_ACCUMULATOR,
    MIS_BCD_ADJUST,
    MIS_MEM_MINUS_ONE,
    MIS_MEM_MINUS_ONE_TO_ACCUMULATOR,
    MIS_SLEEP
  } mis_op_t;

  typedef struct packed {
    mis_op_t op;
    logic [7:0] maddr;
    logic [2:0] bit_sel;
    logic [15:0] target;
  } mis_ins_t;

  typedef enum {ST_RUN, ST_CALL2, ST_SLEEP} mis_state_t;
  typedef enum {PRE_NONE, PRE_FIRST, PRE_SECOND} mis_pre_t;
endpackage : mis_pkg

// ===== sim/mis_props.sv
module mis_props #(
  parameter int PC_W = 10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // instruction issue
  input wire logic ins_valid,
  input wire mis_pkg::mis_ins_t ins,
  input wire logic ins_ready,
  input wire logic [PC_W-1:0] pc_o,
  // watchdog and power
  input wire logic wake_i,
  input wire logic wdt_clear_o,
  input wire logic sleep_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import mis_pkg::*;
  logic take;
  logic clr_ev;
  logic c1_r;
  logic c2_r;
  mis_op_t last_r;
  assign take = ins_valid && ins_ready;
  // a pre-clear counts only against the last instruction actually taken
  assign clr_ev = take && (ins.op == MIS_CLR_WDT || ins.op == MIS_SLEEP ||
    (ins.op == MIS_WATCHDOG_PRECLEAR_SECOND && last_r == MIS_WATCHDOG_PRECLEAR_FIRST) ||
    (ins.op == MIS_WATCHDOG_PRECLEAR_FIRST && last_r == MIS_WATCHDOG_PRECLEAR_SECOND));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= MIS_NOP;
      c1_r <= 1'b0;
      c2_r <= 1'b0;
    end else begin
      if (take) last_r <= ins.op;
      c1_r <= clr_ev;
      c2_r <= c1_r;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  call_stall_a: assert property (
    take && ins.op == MIS_CALL |=> !ins_ready ##1 ins_ready) else $error("call stall wrong");
  call_target_a: assert property (
    take && ins.op == MIS_CALL |=> ##1 pc_o == $past(ins.target[PC_W-1:0], 2))
    else $error("call target not loaded");
  pc_step_a: assert property (
    take |=> pc_o == $past(pc_o) + 1'b1) else $error("pc not advanced by one");
  sleep_enter_a: assert property (
    take && ins.op == MIS_SLEEP |=> sleep_o && wdt_clear_o) else $error("sleep entry wrong");
  sleep_hold_a: assert property (
    sleep_o && !wake_i |=> sleep_o && !ins_ready && $stable(pc_o)) else $error("ran in sleep");
  wdt_clear_a: assert property (
    take && ins.op == MIS_CLR_WDT |-> ##[1:2] wdt_clear_o) else $error("no watchdog clear");
  pair_clear_a: assert property (
    take && ins.op == MIS_WATCHDOG_PRECLEAR_SECOND && last_r == MIS_WATCHDOG_PRECLEAR_FIRST
    |-> ##[1:2] wdt_clear_o) else $error("pair did not clear");
  clear_cause_a: assert property (
    wdt_clear_o |-> c1_r || c2_r) else $error("watchdog clear without cause");
endmodule : mis_props
bind mis_core mis_props #(.PC_W(PC_W)) i_mis_props (.pclk(pclk), .presetn(presetn),
  .ins_valid(ins_valid), .ins(ins), .ins_ready(ins_ready), .pc_o(pc_o), .wake_i(wake_i),
  .wdt_clear_o(wdt_clear_o), .sleep_o(sleep_o));

// ===== sim/mis_wdt_model.sv
module mis_wdt_model #(
  parameter int LIMIT = 40,
  parameter int WAKE_DLY = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // device side
  input wire logic wdt_clear_o,
  input wire logic sleep_o,
  output logic wdt_timeout_i,
  output logic wake_i
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  int slp;
  // frozen while asleep, the system clock is stopped there
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      wdt_timeout_i <= 1'b0;
    end else begin
      wdt_timeout_i <= cnt == LIMIT - 1 && !sleep_o;
      if (wdt_clear_o || cnt == LIMIT - 1) cnt <= 0;
      else if (!sleep_o) cnt <= cnt + 1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slp <= 0;
      wake_i <= 1'b0;
    end else begin
      slp <= sleep_o ? slp + 1 : 0;
      wake_i <= sleep_o && slp >= WAKE_DLY;
    end
  end
endmodule : mis_wdt_model

// ===== sim/tb_top.sv
`define TB_CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mis_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ins_valid = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  mis_ins_t ins = '0;
  logic [31:0] prdata;
  logic pready, pslverr, ins_ready, wdt_timeout_i, wake_i, wdt_clear_o, sleep_o, irq;
  logic [9:0] pc_o;
  logic [64:0] expq[$];
  logic [64:0] q;
  int error_cnt = 0;
  int compares = 0;
  mis_op_t ops[6] = '{MIS_CLR_MEM, MIS_CLR_BIT, MIS_INVERT_MEM, MIS_INVERT_TO_ACCUMULATOR,
    MIS_MEM_MINUS_ONE, MIS_MEM_MINUS_ONE_TO_ACCUMULATOR};
  always #2 pclk = ~pclk;
  mis_core i_mis_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ins_valid(ins_valid), .ins(ins), .ins_ready(ins_ready), .pc_o(pc_o),
    .wdt_timeout_i(wdt_timeout_i), .wake_i(wake_i), .wdt_clear_o(wdt_clear_o),
    .sleep_o(sleep_o), .irq(irq));
  mis_wdt_model i_mis_wdt_model (.pclk(pclk), .presetn(presetn), .wdt_clear_o(wdt_clear_o),
    .sleep_o(sleep_o), .wdt_timeout_i(wdt_timeout_i), .wake_i(wake_i));
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      q = expq.pop_front();
      `TB_CHK(prdata & q[63:32], q[31:0])
      `TB_CHK(pslverr, q[64])
    end
  end
  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  function automatic logic sig(int k);
    return k == 0 ? pready : k == 1 ? ins_ready : k == 2 ? wdt_timeout_i : !sleep_o;
  endfunction : sig
  task automatic wt(int k);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sig(k) !== 1'b1 && n < 200);
    if (n >= 200) begin
      error_cnt++;
      wrap_up();
    end
  endtask : wt
  // reads carry their expectation; the monitor compares when the answer lands
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [31:0] m = '1,
      logic e = 0);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) expq.push_back({e, m, d & m});
    @(posedge pclk);
    penable <= 1;
    wt(0);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic issue(mis_op_t op, logic [7:0] a = 0, logic [2:0] b = 0, logic [15:0] t = 0);
    ins_valid <= 1;
    ins <= '{op, a, b, t};
    wt(1);
    ins_valid <= 0;
    @(posedge pclk);
  endtask : issue
  initial begin
    int i;
    logic [7:0] a, v, m;
    logic [2:0] b;
    logic [10:0] f, r;
    logic [8:0] s;
    logic [15:0] t;
    mis_op_t op;
    void'($urandom(83));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h000, 0);
    apb(0, 12'h010, 0);
    apb(0, 12'h014, 0);
    apb(0, 12'h020, 0, '1, 1);
    t = 16'($urandom);
    issue(MIS_CALL, 0, 0, t);
    apb(0, 12'h004, 32'h10000 | t, 32'h703ff);
    apb(0, 12'h018, 1, 32'h3ff);
    for (i = 0; i < 30; i++) begin
      op = i < 18 ? ops[i % 6] : MIS_BCD_ADJUST;
      v = i < 6 ? 8'h01 : i < 12 ? 8'hff : 8'($urandom);
      f = 11'($urandom);
      a = 8'($urandom % 64);
      b = 3'($urandom);
      m = v;
      r = f;
      s = {1'b0, f[7:0]} + (f[3:0] > 9 || f[10] ? 9'h06 : 9'h0)
        + (f[7:4] > 9 || f[9] ? 9'h60 : 9'h0);
      case (op)
        MIS_CLR_MEM: m = 0;
        MIS_CLR_BIT: m[b] = 1'b0;
        MIS_INVERT_MEM: m = ~v;
        MIS_INVERT_TO_ACCUMULATOR: begin
          r[7:0] = ~v;
          r[8] = v == 8'hff;
        end
        MIS_MEM_MINUS_ONE: begin
          m = v - 1;
          r[8] = m == 0;
        end
        MIS_BCD_ADJUST: begin
          m = s[7:0];
          r[9] = s[8] | f[9];
        end
        default: begin
          r[7:0] = v - 1;
          r[8] = v == 1;
        end
      endcase
      apb(1, 12'h000, 32'(f));
      apb(1, 12'h008, 32'(a));
      apb(1, 12'h00c, 32'(v));
      issue(op, a, b);
      apb(0, 12'h00c, 32'(m));
      apb(0, 12'h000, 32'(r), 32'h7ff);
    end
    wt(2);
    issue(MIS_WATCHDOG_PRECLEAR_FIRST);
    issue(MIS_WATCHDOG_PRECLEAR_FIRST);
    apb(0, 12'h000, 32'h800, 32'h1800);
    issue(MIS_WATCHDOG_PRECLEAR_SECOND);
    apb(0, 12'h000, 0, 32'h1800);
    wt(2);
    issue(MIS_CLR_WDT);
    apb(0, 12'h000, 0, 32'h1800);
    apb(1, 12'h014, 1);
    issue(MIS_SLEEP);
    apb(0, 12'h000, 32'h3000, 32'h3800);
    apb(0, 12'h010, 3, 3);
    `TB_CHK(irq, 1'b1)
    wt(3);
    issue(MIS_WATCHDOG_PRECLEAR_FIRST);
    issue(MIS_NOP);
    issue(MIS_WATCHDOG_PRECLEAR_SECOND);
    apb(0, 12'h000, 32'h1000, 32'h1800);
    issue(MIS_WATCHDOG_PRECLEAR_FIRST);
    apb(0, 12'h000, 0, 32'h1800);
    apb(1, 12'h010, 7);
    `TB_CHK(irq, 1'b0)
    apb(0, 12'h010, 0, 1);
    repeat (4) issue(MIS_CALL, 0, 0, t);
    apb(0, 12'h004, 32'h40000, 32'h70000);
    apb(0, 12'h010, 4, 4);
    wrap_up();
  end
endmodule : tb_top
